//--- logic/vic_pkg.sv
package vic_pkg;

  localparam int NSRC = 18;
  localparam int CCF_W = 6;

  // register map, byte-wide registers on the special-register port
  localparam logic [7:0] ADDR_ENA_A  = 8'hB0;
  localparam logic [7:0] ADDR_ENA_B  = 8'hB1;
  localparam logic [7:0] ADDR_ENA_C  = 8'hB2;
  localparam logic [7:0] ADDR_PRI_A  = 8'hB3;
  localparam logic [7:0] ADDR_PRI_B  = 8'hB4;
  localparam logic [7:0] ADDR_PRI_C  = 8'hB5;
  localparam logic [7:0] ADDR_PAGE   = 8'hB6;
  localparam logic [7:0] ADDR_SECOND = 8'hB7;
  localparam logic [7:0] ADDR_THIRD  = 8'hA7;

  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // field widths of the enable and priority groups
  localparam int GRP_A_W = 7;
  localparam int GRP_B_W = 8;
  localparam int GRP_C_W = 3;

  localparam logic [15:0] VEC_RESET   = 16'h0000;
  localparam logic [15:0] VEC_BASE    = 16'h0003;
  localparam logic [15:0] VEC_STEP    = 16'h0008;
  localparam logic [15:0] VEC_REGDROP = 16'h007B;
  localparam logic [15:0] VEC_PMATCH  = 16'h008B;

  // source order positions
  localparam logic [4:0] SRC_EXT0    = 5'h00;
  localparam logic [4:0] SRC_TMR0    = 5'h01;
  localparam logic [4:0] SRC_EXT1    = 5'h02;
  localparam logic [4:0] SRC_TMR1    = 5'h03;
  localparam logic [4:0] SRC_REGDROP = 5'h0F;
  localparam logic [4:0] SRC_CAN     = 5'h10;
  localparam logic [4:0] SRC_PMATCH  = 5'h11;

  typedef struct packed {
    logic             ext_in0_pending;
    logic             timer_zero_overflow;
    logic             ext_in1_pending;
    logic             timer_one_overflow;
    logic             serial_rx_flag;
    logic             serial_tx_flag;
    logic             timer_two_high_ovf;
    logic             timer_two_low_ovf;
    logic             sp_transfer_done;
    logic             sp_write_collision;
    logic             sp_mode_fault;
    logic             sp_rx_overrun;
    logic             two_wire_flag;
    logic             conv_window_flag;
    logic             conv_done_flag;
    logic             counter_array_ovf;
    logic [CCF_W-1:0] capture_compare_flag;
    logic             waveform_cycle_ovf;
    logic             cmp_a_rise_flag;
    logic             cmp_a_fall_flag;
    logic             cmp_b_rise_flag;
    logic             cmp_b_fall_flag;
    logic             timer_three_high_ovf;
    logic             timer_three_low_ovf;
    logic             line_bus_flag;
    logic             regulator_dropout;
    logic             can_pending_flag;
    logic             port_match;
  } src_flags_t;

  typedef struct packed {
    logic ext0;
    logic tmr0;
    logic ext1;
    logic tmr1;
    logic can;
  } hw_clear_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_CLR  = 2'b11
  } vic_state_t;

  function automatic logic [15:0] vector_of(input logic [4:0] idx);
    vector_of = VEC_BASE + {8'h00, idx, 3'b000};
  endfunction

endpackage

//--- logic/int_arbiter.sv
`timescale 1ns/100ps
module int_arbiter
  import vic_pkg::*;
(
  // request set
  input  wire logic [NSRC-1:0] req,
  // winner
  output logic                 valid,
  output logic [4:0]           idx
);

  // walk downwards so the lowest position is the last to win
  always_comb begin
    valid = 1'b0;
    idx   = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx   = 5'(i);
      end
    end
  end

endmodule // int_arbiter

//--- logic/vectored_interrupt_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - each source has a fixed vector, 0x0003 plus 8 bytes per position.
// - same-level ties go to the lowest order position, 0 to 17.
// - both external input flags are cleared by hardware on vectoring.
// - serial rx or tx flag raises the request; software clears them.
// - timer two or three high/low overflow raise requests; software clears.
// - any of four serial peripheral flags raises its request.
// - counter array overflow, capture/compare or waveform overflow request.
// - comparator rise or fall flag raises that comparator's request.
// - converter window and done flags raise two separate requests.
// - network pending flag is cleared by hardware on vectoring.
// - dropout and port match request with no flag, 0x007B and 0x008B.
// - each source gated by its enable bit in three enable registers.
// - each source has one priority bit at the enable bit position.
// - three-entry page stack pushed on entry, popped on return.
// - on return the third entry moves into the second entry.
// - third-entry register writes and reads the third entry directly.
// - register accesses never push or pop the page stack.
module vectored_interrupt_ctrl
  import vic_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // peripheral flags, same clock domain
  input  src_flags_t       flags,
  // special-register port from the core
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata_q,
  // core vectoring handshake
  output logic             irq_req_q,
  output logic      [15:0] irq_vector_q,
  output logic             irq_high_q,
  input  wire logic        irq_ack,
  input  wire logic        irq_return,
  // hardware clear strobes and current page
  output hw_clear_t        hw_clear_q,
  output logic      [7:0]  current_page_entry_q
);

  logic [GRP_A_W-1:0] enable_reg_a_q;
  logic [GRP_B_W-1:0] enable_reg_b_q;
  logic [GRP_C_W-1:0] enable_reg_c_q;
  logic [GRP_A_W-1:0] priority_reg_a_q;
  logic [GRP_B_W-1:0] priority_reg_b_q;
  logic [GRP_C_W-1:0] priority_reg_c_q;
  logic [7:0]         page_stack_second_entry_q;
  logic [7:0]         page_stack_third_entry_q;
  logic [7:0]         page_d;
  logic [7:0]         second_d;
  logic [7:0]         third_d;
  logic               in_low_q;
  logic               in_high_q;
  logic [4:0]         sel_idx_q;
  vic_state_t         state_q;
  vic_state_t         state_d;

  // pending conditions in order position
  wire logic [NSRC-1:0] pend;
  wire logic [NSRC-1:0] en_all;
  wire logic [NSRC-1:0] pri_all;
  wire logic [NSRC-1:0] act;
  wire logic [NSRC-1:0] hi_set;
  wire logic [NSRC-1:0] lo_set;
  wire logic            hi_valid;
  wire logic            lo_valid;
  wire logic [4:0]      hi_idx;
  wire logic [4:0]      lo_idx;
  wire logic            hi_ok;
  wire logic            lo_ok;
  wire logic            cand_valid;
  wire logic [4:0]      cand_idx;
  wire logic            take;
  wire logic            wr_hit;

  assign pend[0]  = flags.ext_in0_pending;
  assign pend[1]  = flags.timer_zero_overflow;
  assign pend[2]  = flags.ext_in1_pending;
  assign pend[3]  = flags.timer_one_overflow;
  assign pend[4]  = flags.serial_rx_flag | flags.serial_tx_flag;
  assign pend[5]  = flags.timer_two_high_ovf
                  | flags.timer_two_low_ovf;
  assign pend[6]  = flags.sp_transfer_done | flags.sp_write_collision
                  | flags.sp_mode_fault | flags.sp_rx_overrun;
  assign pend[7]  = flags.two_wire_flag;
  assign pend[8]  = flags.conv_window_flag;
  assign pend[9]  = flags.conv_done_flag;
  assign pend[10] = flags.counter_array_ovf
                  | (|flags.capture_compare_flag)
                  | flags.waveform_cycle_ovf;
  assign pend[11] = flags.cmp_a_rise_flag | flags.cmp_a_fall_flag;
  assign pend[12] = flags.cmp_b_rise_flag | flags.cmp_b_fall_flag;
  assign pend[13] = flags.timer_three_high_ovf
                  | flags.timer_three_low_ovf;
  assign pend[14] = flags.line_bus_flag;
  // no flag behind dropout (15) and port match (17): the request is the source level itself
  assign pend[15] = flags.regulator_dropout;
  assign pend[16] = flags.can_pending_flag;
  assign pend[17] = flags.port_match;

  assign en_all  = {enable_reg_c_q, enable_reg_b_q,
                    enable_reg_a_q};
  assign pri_all = {priority_reg_c_q, priority_reg_b_q,
                    priority_reg_a_q};
  assign act     = pend & en_all;
  assign hi_set  = act & pri_all;
  assign lo_set  = act & ~pri_all;

  int_arbiter u_hi_arb (
    .req   (hi_set),
    .valid (hi_valid),
    .idx   (hi_idx)
  );

  int_arbiter u_lo_arb (
    .req   (lo_set),
    .valid (lo_valid),
    .idx   (lo_idx)
  );

  // a high request may interrupt a low handler, never the reverse
  assign hi_ok      = hi_valid & ~in_high_q;
  assign lo_ok      = lo_valid & ~in_high_q & ~in_low_q;
  assign cand_valid = hi_ok | lo_ok;
  assign cand_idx   = hi_ok ? hi_idx : lo_idx;
  assign take       = irq_req_q & irq_ack;
  assign wr_hit     = sfr_wr & ~take & ~irq_return;

  // sequencer: the clear state gives the flag one cycle to fall
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (cand_valid) state_d = ST_REQ;
      ST_REQ: begin
        if (take) begin
          state_d = ST_CLR;
        end else if (!cand_valid) begin
          state_d = ST_IDLE;
        end
      end
      ST_CLR:  state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= ST_IDLE;
      irq_req_q    <= 1'b0;
      irq_vector_q <= VEC_RESET;
      irq_high_q   <= 1'b0;
      sel_idx_q    <= 5'h00;
    end else begin
      state_q   <= state_d;
      irq_req_q <= (state_d == ST_REQ);
      // vector follows the winner until the core takes it
      if (state_d == ST_REQ) begin
        irq_vector_q <= vector_of(cand_idx);
        irq_high_q   <= hi_ok;
        sel_idx_q    <= cand_idx;
      end
    end
  end

  // in-service levels, a return retires the higher one first
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      in_low_q  <= 1'b0;
      in_high_q <= 1'b0;
    end else if (take) begin
      if (irq_high_q) begin
        in_high_q <= 1'b1;
      end else begin
        in_low_q <= 1'b1;
      end
    end else if (irq_return) begin
      if (in_high_q) begin
        in_high_q <= 1'b0;
      end else begin
        in_low_q <= 1'b0;
      end
    end
  end

  // one-cycle clear strobes for the flags that hardware clears
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hw_clear_q <= '0;
    end else begin
      hw_clear_q.ext0 <= take & (sel_idx_q == SRC_EXT0);
      hw_clear_q.ext1 <= take & (sel_idx_q == SRC_EXT1);
      hw_clear_q.tmr0 <= take & (sel_idx_q == SRC_TMR0);
      hw_clear_q.tmr1 <= take & (sel_idx_q == SRC_TMR1);
      hw_clear_q.can  <= take & (sel_idx_q == SRC_CAN);
    end
  end

  // page stack; a shift wins over a register write in the same cycle
  always_comb begin
    page_d   = current_page_entry_q;
    second_d = page_stack_second_entry_q;
    third_d  = page_stack_third_entry_q;
    if (take) begin
      second_d = current_page_entry_q;
      third_d  = page_stack_second_entry_q;
    end else if (irq_return) begin
      page_d   = page_stack_second_entry_q;
      second_d = page_stack_third_entry_q;
    end else if (wr_hit) begin
      if (sfr_addr == ADDR_PAGE) page_d = sfr_wdata;
      if (sfr_addr == ADDR_SECOND) second_d = sfr_wdata;
      if (sfr_addr == ADDR_THIRD) third_d = sfr_wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      current_page_entry_q      <= PAGE_RST;
      page_stack_second_entry_q <= PAGE_RST;
      page_stack_third_entry_q  <= PAGE_RST;
    end else begin
      current_page_entry_q      <= page_d;
      page_stack_second_entry_q <= second_d;
      page_stack_third_entry_q  <= third_d;
    end
  end

  // enable and priority registers, writable at any time
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      enable_reg_a_q   <= REG_RST[GRP_A_W-1:0];
      enable_reg_b_q   <= REG_RST[GRP_B_W-1:0];
      enable_reg_c_q   <= REG_RST[GRP_C_W-1:0];
      priority_reg_a_q <= REG_RST[GRP_A_W-1:0];
      priority_reg_b_q <= REG_RST[GRP_B_W-1:0];
      priority_reg_c_q <= REG_RST[GRP_C_W-1:0];
    end else if (sfr_wr) begin
      case (sfr_addr)
        ADDR_ENA_A: enable_reg_a_q   <= sfr_wdata[GRP_A_W-1:0];
        ADDR_ENA_B: enable_reg_b_q   <= sfr_wdata[GRP_B_W-1:0];
        ADDR_ENA_C: enable_reg_c_q   <= sfr_wdata[GRP_C_W-1:0];
        ADDR_PRI_A: priority_reg_a_q <= sfr_wdata[GRP_A_W-1:0];
        ADDR_PRI_B: priority_reg_b_q <= sfr_wdata[GRP_B_W-1:0];
        ADDR_PRI_C: priority_reg_c_q <= sfr_wdata[GRP_C_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux; unused bits and unmapped addresses read zero
  wire logic [7:0] rd_mux =
    (sfr_addr == ADDR_ENA_A)  ? {1'b0, enable_reg_a_q} :
    (sfr_addr == ADDR_ENA_B)  ? enable_reg_b_q :
    (sfr_addr == ADDR_ENA_C)  ? {5'h00, enable_reg_c_q} :
    (sfr_addr == ADDR_PRI_A)  ? {1'b0, priority_reg_a_q} :
    (sfr_addr == ADDR_PRI_B)  ? priority_reg_b_q :
    (sfr_addr == ADDR_PRI_C)  ? {5'h00, priority_reg_c_q} :
    (sfr_addr == ADDR_PAGE)   ? current_page_entry_q :
    (sfr_addr == ADDR_SECOND) ? page_stack_second_entry_q :
    (sfr_addr == ADDR_THIRD)  ? page_stack_third_entry_q :
                                8'h00;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_q <= rd_mux;
    end
  end

  // helper state read only by the checks below
  logic [NSRC-1:0] win_set_q;
  logic [NSRC-1:0] act_q;
  logic [NSRC-1:0] pri_q;
  // sampled alongside the winner so the index lines up with its cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      win_set_q <= '0;
      act_q     <= '0;
      pri_q     <= '0;
    end else begin
      win_set_q <= hi_ok ? hi_set : lo_set;
      act_q     <= act;
      pri_q     <= pri_all;
    end
  end

  function automatic logic [NSRC-1:0] below(input logic [4:0] idx);
    below = NSRC'((32'h1 << idx) - 32'h1);
  endfunction

  a_vec_spacing: assert property (
    @(posedge mclk) disable iff (!nrst)
    irq_req_q |-> irq_vector_q == VEC_BASE + 16'(sel_idx_q) * VEC_STEP)
    else $error("vector not at base plus eight per position");

  a_vec_flagless: assert property (
    @(posedge mclk) disable iff (!nrst)
    (irq_req_q && sel_idx_q == SRC_PMATCH |-> irq_vector_q == VEC_PMATCH)
    and (irq_req_q && sel_idx_q == SRC_REGDROP
         |-> irq_vector_q == VEC_REGDROP))
    else $error("flagless source vector wrong");

  a_fixed_order: assert property (
    @(posedge mclk) disable iff (!nrst)
    irq_req_q |-> (win_set_q & below(sel_idx_q)) == '0)
    else $error("lower position lost arbitration");

  a_enable_gate: assert property (
    @(posedge mclk) disable iff (!nrst)
    irq_req_q |-> act_q[sel_idx_q])
    else $error("request without pending and enable");

  a_level_match: assert property (
    @(posedge mclk) disable iff (!nrst)
    irq_req_q |-> irq_high_q == pri_q[sel_idx_q])
    else $error("request level differs from priority bit");

  a_preempt_low: assert property (
    @(posedge mclk) disable iff (!nrst)
    state_q == ST_IDLE && in_low_q && !in_high_q && hi_valid
    |=> irq_req_q && irq_high_q)
    else $error("high request did not preempt low handler");

  a_clear_ext: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && (sel_idx_q == SRC_EXT0 || sel_idx_q == SRC_EXT1)
    |=> (hw_clear_q.ext0 | hw_clear_q.ext1)
    ##1 (!hw_clear_q.ext0 && !hw_clear_q.ext1))
    else $error("external input flag not cleared once");

  a_clear_timer: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && sel_idx_q == SRC_TMR1 |=> hw_clear_q.tmr1 && !hw_clear_q.tmr0)
    else $error("timer flag clear strobe wrong");

  a_clear_can: assert property (
    @(posedge mclk) disable iff (!nrst)
    hw_clear_q.can |-> $past(take) && $past(sel_idx_q) == SRC_CAN)
    else $error("network clear without vectoring");

  a_stack_push: assert property (
    @(posedge mclk) disable iff (!nrst)
    take |=> page_stack_second_entry_q == $past(current_page_entry_q)
    && page_stack_third_entry_q == $past(page_stack_second_entry_q))
    else $error("page stack push wrong");

  a_stack_pop: assert property (
    @(posedge mclk) disable iff (!nrst)
    irq_return && !take
    |=> current_page_entry_q == $past(page_stack_second_entry_q)
    && page_stack_second_entry_q == $past(page_stack_third_entry_q)
    && $stable(page_stack_third_entry_q))
    else $error("page stack pop wrong");

  a_third_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    wr_hit && sfr_addr == ADDR_THIRD
    |=> page_stack_third_entry_q == $past(sfr_wdata)
    && $stable(current_page_entry_q)
    && $stable(page_stack_second_entry_q))
    else $error("third entry write shifted the stack");

endmodule // vectored_interrupt_ctrl

//--- dv/core_model.sv
`timescale 1ns/100ps
module core_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // request from the controller
  input  wire logic        irq_req_q,
  input  wire logic [15:0] irq_vector_q,
  // bench control
  input  wire logic [3:0]  ack_dly,
  input  wire logic        ret_cmd,
  // handshake back
  output logic             irq_ack,
  output logic             irq_return,
  output logic      [15:0] taken_vec
);
  logic [3:0] wait_q;

  // a slow core leaves the request standing, so a better source may win
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
      taken_vec  <= 16'h0000;
      wait_q     <= 4'h0;
    end else begin
      irq_ack    <= 1'b0;
      irq_return <= ret_cmd;
      // the vector counts at the edge that takes it, not when ack rises
      if (irq_req_q && irq_ack) begin
        taken_vec <= irq_vector_q;
      end
      if (irq_req_q && !irq_ack && wait_q >= ack_dly) begin
        irq_ack   <= 1'b1;
        wait_q    <= 4'h0;
      end else if (irq_req_q && !irq_ack) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule // core_model

//--- dv/tb_vectored_interrupt_ctrl.sv
`timescale 1ns/100ps
module tb_vectored_interrupt_ctrl
  import vic_pkg::*;
;
  // highest flag bit of each position and how many flags share it
  localparam int BASE[18] = '{32,31,30,29,28,26,24,20,19,18,17,9,7,5,3,2,1,0};
  localparam int ALTS[18] = '{1,1,1,1,2,2,4,1,1,1,8,2,2,2,1,1,1,1};

  logic        mclk, nrst, sfr_wr, sfr_rd, ret_cmd, hi;
  logic        irq_req_q, irq_high_q, irq_ack, irq_return;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q, current_page_entry_q;
  logic [15:0] irq_vector_q, taken_vec;
  logic [3:0]  ack_dly;
  logic [31:0] lfsr;
  src_flags_t  flags;
  hw_clear_t   hw_clear_q;
  int          fail_count, n_tests, p, q, k;

  vectored_interrupt_ctrl dut (.mclk(mclk), .nrst(nrst), .flags(flags),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q),
    .irq_high_q(irq_high_q), .irq_ack(irq_ack), .irq_return(irq_return),
    .hw_clear_q(hw_clear_q), .current_page_entry_q(current_page_entry_q));

  core_model core (.mclk(mclk), .nrst(nrst), .irq_req_q(irq_req_q),
    .irq_vector_q(irq_vector_q), .ack_dly(ack_dly), .ret_cmd(ret_cmd),
    .irq_ack(irq_ack), .irq_return(irq_return), .taken_vec(taken_vec));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic src_flags_t flag_for(input int n, input logic [2:0] r);
    logic [32:0] v;
    v = '0;
    v[BASE[n] - int'(r) % ALTS[n]] = 1'b1;
    return src_flags_t'(v);
  endfunction

  function automatic logic [15:0] exp_vec(input int n);
    return 16'h0003 + 16'(n) * 16'h0008;
  endfunction

  function automatic logic [15:0] exp_clr(input int n);
    case (n)
      0: return 16'h0010;
      1: return 16'h0008;
      2: return 16'h0004;
      3: return 16'h0002;
      16: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge mclk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge mclk);
    sfr_rd   <= 1'b0;
    #1;
    chk({8'h00, sfr_rdata_q}, e);
  endtask

  // enable or priority group: base address, then the next two
  task automatic wr3(input logic [7:0] a, input logic [17:0] m);
    wr(a, {1'b0, m[6:0]});
    wr(a + 8'h01, m[14:7]);
    wr(a + 8'h02, {5'h00, m[17:15]});
  endtask

  task automatic do_ret;
    @(posedge mclk);
    ret_cmd <= 1'b1;
    @(posedge mclk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic serve(input src_flags_t f, input int n, input logic h,
                       input logic ret);
    @(posedge mclk);
    flags <= f;
    for (int i = 0; i < 40 && irq_ack !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({15'h0000, irq_ack}, 16'h0001);
    chk(irq_vector_q, exp_vec(n));
    chk({15'h0000, irq_high_q}, {15'h0000, h});
    @(posedge mclk);
    #1;
    chk({11'h000, hw_clear_q}, exp_clr(n));
    chk(taken_vec, exp_vec(n));
    @(posedge mclk);
    flags <= '0;
    if (ret) do_ret;
  endtask

  task summarize;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    summarize;
  end

  initial begin
    {nrst, sfr_wr, sfr_rd, ret_cmd} = 4'h0;
    {sfr_addr, sfr_wdata} = 16'h0000;
    flags = '0;
    ack_dly = 4'h0;
    lfsr = 32'h0001650E;
    fail_count = 0;
    n_tests = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk(irq_vector_q, 16'h0000);
    rdc(ADDR_THIRD, 16'h0000);
    rdc(8'hC3, 16'h0000);
    $display("test reset done");
    // every source alone, first with its enable clear
    for (p = 0; p < 18; p++) begin
      lfsr = nxt(lfsr);
      hi = lfsr[4];
      ack_dly <= lfsr[3:0];
      wr3(ADDR_PRI_A, {17'h00000, hi} << p);
      @(posedge mclk);
      flags <= flag_for(p, lfsr[10:8]);
      repeat (3) @(posedge mclk);
      #1;
      chk({15'h0000, irq_req_q}, 16'h0000);
      @(posedge mclk);
      flags <= '0;
      wr3(ADDR_ENA_A, 18'h00001 << p);
      serve(flag_for(p, lfsr[10:8]), p, hi, 1'b1);
      wr3(ADDR_ENA_A, 18'h00000);
    end
    $display("test sources done");
    // same-level pairs, lower position must win
    for (k = 0; k < 8; k++) begin
      lfsr = nxt(lfsr);
      p = int'(lfsr[7:0]) % 17;
      q = p + 1 + int'(lfsr[15:8]) % (17 - p);
      if (k == 0) begin
        p = 16;
        q = 17;
      end
      hi = lfsr[16];
      ack_dly <= lfsr[19:16];
      wr3(ADDR_PRI_A, hi ? (18'h00001 << p) | (18'h00001 << q) : 18'h0);
      wr3(ADDR_ENA_A, (18'h00001 << p) | (18'h00001 << q));
      serve(flag_for(p, lfsr[2:0]) | flag_for(q, lfsr[5:3]), p, hi,
            1'b1);
    end
    $display("test ties done");
    ack_dly <= 4'h0;
    wr3(ADDR_PRI_A, 18'h01000);
    wr3(ADDR_ENA_A, 18'h01200);
    rdc(ADDR_ENA_B, 16'h0024);
    serve(flag_for(9, 3'h0), 9, 1'b0, 1'b0);
    serve(flag_for(12, 3'h0), 12, 1'b1, 1'b1);
    do_ret;
    $display("test preempt done");
    wr(ADDR_PAGE, 8'h11);
    wr(ADDR_SECOND, 8'h22);
    wr(ADDR_THIRD, 8'h33);
    rdc(ADDR_THIRD, 16'h0033);
    rdc(ADDR_SECOND, 16'h0022);
    chk({8'h00, current_page_entry_q}, 16'h0011);
    serve(flag_for(9, 3'h0), 9, 1'b0, 1'b0);
    rdc(ADDR_SECOND, 16'h0011);
    rdc(ADDR_THIRD, 16'h0022);
    wr(ADDR_PAGE, 8'h44);
    wr(ADDR_THIRD, 8'h55);
    do_ret;
    chk({8'h00, current_page_entry_q}, 16'h0011);
    rdc(ADDR_SECOND, 16'h0055);
    rdc(ADDR_THIRD, 16'h0055);
    $display("test page stack done");
    summarize;
  end
endmodule // tb_vectored_interrupt_ctrl
